// [rtl/bmdt_defs.svh]
`ifndef BMDT_DEFS_SVH
`define BMDT_DEFS_SVH

// number of trigger blocks held
`define BMDT_DEPTH 16
// link index meaning "no change" (eom) or "sequence ends" (next)
`define BMDT_NO_LINK 8'hff

// qualifier field bit positions
`define BMDT_SPEC_PRIMARY 5
`define BMDT_SPEC_SECONDARY 4
`define BMDT_SPEC_CMD2 3
`define BMDT_SPEC_STATUS 2
`define BMDT_SPEC_DATA 1
`define BMDT_SPEC_CMD 0

// configuration field selectors
`define BMDT_FLD_KIND 4'h0
`define BMDT_FLD_OPTIONS 4'h1
`define BMDT_FLD_RESET_MASK 4'h2
`define BMDT_FLD_SET_MASK 4'h3
`define BMDT_FLD_SPEC 4'h4
`define BMDT_FLD_NEXT 4'h5
`define BMDT_FLD_EOM 4'h6
`define BMDT_FLD_DATA 4'h7
`define BMDT_FLD_MASK 4'h8
`define BMDT_FLD_UPPER 4'h9
`define BMDT_FLD_LOWER 4'ha

// options field bits
`define BMDT_OPT_STROBE 0
`define BMDT_OPT_IRQ 1
`define BMDT_OPT_INVERT 2

`define BMDT_PATTERN_RESET 8'h00

`endif

// [rtl/bmdt_pkg.sv]
package bmdt_pkg;

  typedef enum logic [1:0] {
    KIND_ERROR,
    KIND_EXTERNAL,
    KIND_RECEIVED,
    KIND_VALUE
  } bmdt_kind_t;

  typedef struct packed {
    bmdt_kind_t trigger_kind;
    logic strobe_en;
    logic irq_en;
    logic invert;
    logic [7:0] reset_mask;
    logic [7:0] set_mask;
    logic [7:0] spec;
    logic [7:0] next_idx;
    logic [7:0] eom_idx;
    logic [15:0] data_word;
    logic [15:0] mask_word;
    logic [15:0] upper;
    logic [15:0] lower;
  } bmdt_block_t;

endpackage

// [rtl/bmdt_trigger.sv]
`timescale 1ns/100ps
`include "bmdt_defs.svh"

module bmdt_trigger (
  input wire logic clk,
  input wire logic reset,
  input wire logic cfg_we,
  input wire logic [3:0] cfg_block,
  input wire logic [3:0] cfg_field,
  input wire logic [15:0] cfg_wdata,
  input wire logic [1:0] seq_arm,
  input wire logic [1:0] seq_stop,
  input wire logic [7:0] seq_first0,
  input wire logic [7:0] seq_first1,
  input wire logic word_valid,
  input wire logic [15:0] word_value,
  input wire logic word_primary,
  input wire logic [3:0] word_type,
  input wire logic [5:0] word_pos,
  input wire logic msg_end,
  input wire logic err_valid,
  input wire logic [15:0] err_flags,
  input wire logic ext_trigger_in,
  output logic [7:0] status_pattern,
  output logic trigger_strobe,
  output logic trigger_irq,
  output logic [1:0] seq_active,
  output logic [1:0] seq_hit,
  output logic [7:0] seq_index0,
  output logic [7:0] seq_index1
);

  typedef struct packed {
    bmdt_pkg::bmdt_block_t [`BMDT_DEPTH-1:0] blocks;
    logic [1:0] active;
    logic [1:0][7:0] idx;
    logic [7:0] pattern;
    logic strobe;
    logic irq;
    logic [1:0] hit;
    logic ext_prev;
  } bmdt_state_t;

  bmdt_state_t state_q;
  bmdt_state_t state_d;

  // a link that names a block rather than the end marker
  function automatic logic bmdt_linked(
    input logic [7:0] idx
  );
    bmdt_linked = (idx != `BMDT_NO_LINK);
  endfunction

  // masked word against the block's inclusive limits
  function automatic logic bmdt_in_range(
    input bmdt_pkg::bmdt_block_t b,
    input logic [15:0] w
  );
    logic [15:0] masked;
    masked = w & b.mask_word;
    bmdt_in_range = (masked >= b.lower) && (masked <= b.upper);
  endfunction

  // condition of one block against the current bus event
  function automatic logic bmdt_match(
    input bmdt_pkg::bmdt_block_t b,
    input logic ext_edge
  );
    logic bus_ok;
    logic type_ok;
    logic value_ok;
    bus_ok = (word_primary & b.spec[`BMDT_SPEC_PRIMARY])
      | (~word_primary & b.spec[`BMDT_SPEC_SECONDARY]);
    type_ok = |(word_type & b.spec[3:0]);
    value_ok = ((word_value ^ b.data_word) & b.mask_word) == 16'h0000;
    bmdt_match = 1'b0;
    case (b.trigger_kind)
      bmdt_pkg::KIND_ERROR: begin
        bmdt_match = err_valid && ((err_flags & b.data_word & b.mask_word) != 16'h0000);
      end
      bmdt_pkg::KIND_EXTERNAL: begin
        bmdt_match = ext_edge;
      end
      bmdt_pkg::KIND_RECEIVED: begin
        bmdt_match = word_valid && bus_ok && type_ok && value_ok;
      end
      bmdt_pkg::KIND_VALUE: begin
        bmdt_match = word_valid && word_type[`BMDT_SPEC_DATA]
          && (word_pos == b.spec[5:0])
          && (bmdt_in_range(b, word_value) ^ b.invert);
      end
      default: begin
        bmdt_match = 1'b0;
      end
    endcase
  endfunction

  always_comb begin
    bmdt_pkg::bmdt_block_t cur;
    logic ext_edge;
    logic hit;
    state_d = state_q;
    cur = '0;
    hit = 1'b0;
    ext_edge = ext_trigger_in & ~state_q.ext_prev;
    state_d.ext_prev = ext_trigger_in;
    // pulses last one cycle
    state_d.strobe = 1'b0;
    state_d.irq = 1'b0;
    state_d.hit = 2'b00;

    // one field of one block per write
    if (cfg_we) begin
      case (cfg_field)
        `BMDT_FLD_KIND: begin
          state_d.blocks[cfg_block].trigger_kind = bmdt_pkg::bmdt_kind_t'(cfg_wdata[1:0]);
        end
        `BMDT_FLD_OPTIONS: begin
          state_d.blocks[cfg_block].strobe_en = cfg_wdata[`BMDT_OPT_STROBE];
          state_d.blocks[cfg_block].irq_en = cfg_wdata[`BMDT_OPT_IRQ];
          state_d.blocks[cfg_block].invert = cfg_wdata[`BMDT_OPT_INVERT];
        end
        `BMDT_FLD_RESET_MASK: begin
          state_d.blocks[cfg_block].reset_mask = cfg_wdata[7:0];
        end
        `BMDT_FLD_SET_MASK: begin
          state_d.blocks[cfg_block].set_mask = cfg_wdata[7:0];
        end
        `BMDT_FLD_SPEC: begin
          state_d.blocks[cfg_block].spec = cfg_wdata[7:0];
        end
        `BMDT_FLD_NEXT: begin
          state_d.blocks[cfg_block].next_idx = cfg_wdata[7:0];
        end
        `BMDT_FLD_EOM: begin
          state_d.blocks[cfg_block].eom_idx = cfg_wdata[7:0];
        end
        `BMDT_FLD_DATA: begin
          state_d.blocks[cfg_block].data_word = cfg_wdata;
        end
        `BMDT_FLD_MASK: begin
          state_d.blocks[cfg_block].mask_word = cfg_wdata;
        end
        `BMDT_FLD_UPPER: begin
          state_d.blocks[cfg_block].upper = cfg_wdata;
        end
        `BMDT_FLD_LOWER: begin
          state_d.blocks[cfg_block].lower = cfg_wdata;
        end
        // unknown field codes leave the block as it was
        default: begin
          state_d.blocks[cfg_block] = state_q.blocks[cfg_block];
        end
      endcase
    end

    // both sequences evaluated on the same event, sequence 0 applied first
    for (int s = 0; s < 2; s++) begin
      cur = state_q.blocks[state_q.idx[s][3:0]];
      // an index past the last block never matches; msg_end still follows the eom link of block idx[3:0]
      hit = state_q.active[s] && (state_q.idx[s] < 8'(`BMDT_DEPTH))
        && bmdt_match(cur, ext_edge);
      if (hit) begin
        state_d.pattern = (state_d.pattern & ~cur.reset_mask) | cur.set_mask;
        state_d.strobe = state_d.strobe | cur.strobe_en;
        state_d.irq = state_d.irq | cur.irq_en;
        state_d.hit[s] = 1'b1;
        // new index only looks at events from the next cycle on
        if (bmdt_linked(cur.next_idx)) begin
          state_d.idx[s] = cur.next_idx;
        end else begin
          state_d.active[s] = 1'b0;
        end
      end else if (state_q.active[s] && msg_end) begin
        if (bmdt_linked(cur.eom_idx)) begin
          state_d.idx[s] = cur.eom_idx;
        end
      end
      // arm wins over stop and over a match's index and active updates in the same cycle
      if (seq_stop[s]) begin
        state_d.active[s] = 1'b0;
      end
      if (seq_arm[s]) begin
        state_d.active[s] = 1'b1;
        state_d.idx[s] = (s == 0) ? seq_first0 : seq_first1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      // indices park on the end marker until a sequence is armed
      state_q <= '0;
      state_q.pattern <= `BMDT_PATTERN_RESET;
      state_q.idx <= {`BMDT_NO_LINK, `BMDT_NO_LINK};
    end else begin
      state_q <= state_d;
    end
  end

  assign status_pattern = state_q.pattern;
  assign trigger_strobe = state_q.strobe;
  assign trigger_irq = state_q.irq;
  assign seq_active = state_q.active;
  assign seq_hit = state_q.hit;
  assign seq_index0 = state_q.idx[0];
  assign seq_index1 = state_q.idx[1];

endmodule // bmdt_trigger

// [testbench/bmdt_trigger_sva.sv]
`timescale 1ns/100ps
module bmdt_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] seq_arm,
  input wire logic [1:0] seq_stop,
  input wire logic [7:0] seq_first0,
  input wire logic word_valid,
  input wire logic err_valid,
  input wire logic ext_trigger_in,
  input wire logic [7:0] status_pattern,
  input wire logic trigger_strobe,
  input wire logic trigger_irq,
  input wire logic [1:0] seq_active,
  input wire logic [1:0] seq_hit,
  input wire logic [7:0] seq_index0
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence stop0_s;
    seq_stop[0] && !seq_arm[0];
  endsequence
  strobe_hit_a: assert property (trigger_strobe |-> seq_hit != 2'h0)
    else $error("strobe without hit");
  irq_hit_a: assert property (trigger_irq |-> seq_hit != 2'h0)
    else $error("irq without hit");
  pattern_hit_a: assert property ($changed(status_pattern) |-> seq_hit != 2'h0)
    else $error("pattern moved without hit");
  arm_load_a: assert property (seq_arm[0] |=> seq_active[0] && seq_index0 == $past(seq_first0))
    else $error("arm did not load first block");
  stop_drop_a: assert property (stop0_s |=> !seq_active[0])
    else $error("stop left sequence active");
  hit_zero_a: assert property (seq_hit[0] |-> $past(seq_active[0]))
    else $error("idle sequence zero hit");
  hit_one_a: assert property (seq_hit[1] |-> $past(seq_active[1]))
    else $error("idle sequence one hit");
  hit_cause_a: assert property (seq_hit != 2'h0 |->
    $past(word_valid) || $past(err_valid) || $past(ext_trigger_in))
    else $error("hit without event");
endmodule // bmdt_sva
bind bmdt_trigger bmdt_sva i_bmdt_sva (.*);

// [testbench/bmdt_bus.sv]
`timescale 1ns/100ps
module bmdt_bus (
  input wire logic clk,
  output logic word_valid,
  output logic [15:0] word_value,
  output logic word_primary,
  output logic [3:0] word_type,
  output logic [5:0] word_pos,
  output logic msg_end
);
  initial begin
    word_valid = 1'b0;
    word_value = 16'h0000;
    word_primary = 1'b0;
    word_type = 4'h0;
    word_pos = 6'h00;
    msg_end = 1'b0;
  end
  task automatic send(input logic w, input logic [15:0] v, input logic p,
    input logic [3:0] t, input logic [5:0] n, input logic e);
    @(posedge clk);
    #1;
    word_valid = w;
    word_value = v;
    word_primary = p;
    word_type = t;
    word_pos = n;
    msg_end = e;
    @(posedge clk);
    #1;
    word_valid = 1'b0;
    msg_end = 1'b0;
    // released word shows garbage
    word_value = ~v;
  endtask
endmodule // bmdt_bus

// [testbench/bmdt_trigger_tb.sv]
`timescale 1ns/100ps
module bmdt_trigger_tb;
  logic clk = 1'b0, reset = 1'b1, cfg_we = 1'b0, err_valid = 1'b0, ext_trigger_in = 1'b0;
  logic [3:0] cfg_block = 4'h0, cfg_field = 4'h0;
  logic [15:0] cfg_wdata = 16'h0000, err_flags = 16'h0000, word_value;
  logic [1:0] seq_arm = 2'h0, seq_stop = 2'h0, seq_active, seq_hit;
  logic [7:0] seq_first0 = 8'h00, seq_first1 = 8'h02, status_pattern, seq_index0, seq_index1;
  logic word_valid, word_primary, msg_end, trigger_strobe, trigger_irq;
  logic [3:0] word_type;
  logic [5:0] word_pos;
  int fail_count = 0, tests_run = 0;
  logic [23:0] blocks [$] = '{24'h000002, 24'h010003, 24'h030001, 24'h040021, 24'h050001,
    24'h0600ff, 24'h070c20, 24'h08ff00, 24'h100003, 24'h110002, 24'h120001, 24'h130002,
    24'h140003, 24'h18ffff, 24'h1903e8, 24'h1a0064, 24'h200001, 24'h210001, 24'h230080,
    24'h250003, 24'h2600ff, 24'h330040, 24'h3500ff, 24'h3600ff, 24'h372010, 24'h38ffff,
    24'h400003, 24'h410005, 24'h430010, 24'h440001, 24'h4500ff, 24'h4600ff, 24'h48ffff,
    24'h4900ff, 24'h4a0010};
  initial forever #50 clk = ~clk;
  bmdt_trigger i_bmdt_trigger (.*);
  bmdt_bus i_bmdt_bus (.*);
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [23:0] c);
    step();
    cfg_we = 1'b1;
    {cfg_block, cfg_field, cfg_wdata} = c;
    step();
    cfg_we = 1'b0;
  endtask
  task automatic outs(input logic [1:0] a, input logic [7:0] p, input logic [1:0] h,
    input logic [1:0] s, input logic [7:0] i0, input logic [7:0] i1);
    tests_run++;
    if ({a, p, h, s, i0, i1} !== {seq_active, status_pattern, seq_hit, trigger_strobe,
      trigger_irq, seq_index0, seq_index1}) begin
      fail_count++;
      $display("wrong value outputs expected %h seen %h", {a, p, h, s, i0, i1},
        {seq_active, status_pattern, seq_hit, trigger_strobe, trigger_irq, seq_index0,
        seq_index1});
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    reset = 1'b0;
    outs(2'h0, 8'h00, 2'h0, 2'h0, 8'hff, 8'hff);
    foreach (blocks[k]) wr(blocks[k]);
    seq_arm = 2'h3;
    step();
    seq_arm = 2'h0;
    outs(2'h3, 8'h00, 2'h0, 2'h0, 8'h00, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h0c20, 1'b0, 4'h1, 6'h00, 1'b0);
    outs(2'h3, 8'h00, 2'h0, 2'h0, 8'h00, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h0c20, 1'b1, 4'h2, 6'h01, 1'b0);
    outs(2'h3, 8'h00, 2'h0, 2'h0, 8'h00, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h0c7f, 1'b1, 4'h1, 6'h00, 1'b0);
    outs(2'h3, 8'h01, 2'h1, 2'h3, 8'h01, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h01f4, 1'b1, 4'h2, 6'h02, 1'b0);
    outs(2'h3, 8'h01, 2'h0, 2'h0, 8'h01, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h0032, 1'b1, 4'h2, 6'h03, 1'b1);
    outs(2'h3, 8'h01, 2'h0, 2'h0, 8'h00, 8'h02);
    i_bmdt_bus.send(1'b1, 16'h0c20, 1'b1, 4'h1, 6'h00, 1'b0);
    i_bmdt_bus.send(1'b1, 16'h03e8, 1'b1, 4'h2, 6'h03, 1'b0);
    outs(2'h3, 8'h02, 2'h1, 2'h1, 8'h00, 8'h02);
    i_bmdt_bus.send(1'b0, 16'h0c20, 1'b1, 4'h1, 6'h00, 1'b1);
    outs(2'h3, 8'h02, 2'h0, 2'h0, 8'h00, 8'h02);
    ext_trigger_in = 1'b1;
    step();
    outs(2'h3, 8'h82, 2'h2, 2'h2, 8'h00, 8'h03);
    err_valid = 1'b1;
    err_flags = 16'h0010;
    step();
    err_valid = 1'b0;
    outs(2'h1, 8'hc2, 2'h2, 2'h0, 8'h00, 8'h03);
    seq_stop = 2'h1;
    step();
    seq_stop = 2'h0;
    i_bmdt_bus.send(1'b1, 16'h0c20, 1'b1, 4'h1, 6'h00, 1'b0);
    outs(2'h0, 8'hc2, 2'h0, 2'h0, 8'h00, 8'h03);
    seq_first0 = 8'h04;
    seq_arm = 2'h1;
    step();
    seq_arm = 2'h0;
    outs(2'h1, 8'hc2, 2'h0, 2'h0, 8'h04, 8'h03);
    i_bmdt_bus.send(1'b1, 16'h0020, 1'b1, 4'h2, 6'h01, 1'b0);
    outs(2'h1, 8'hc2, 2'h0, 2'h0, 8'h04, 8'h03);
    i_bmdt_bus.send(1'b1, 16'h0100, 1'b1, 4'h2, 6'h01, 1'b0);
    outs(2'h0, 8'hd2, 2'h1, 2'h2, 8'h04, 8'h03);
    complete_run();
  end
endmodule // bmdt_trigger_tb
